// >>> src/sdlc_receive_framer.sv
// Decided for this implementation: the strobed register port and the register addresses.
`default_nettype none
module sdlc_receive_framer
   import sdlc_rx_pkg::*;
#(
   parameter int FIFO_DEPTH = 3
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   input  wire logic       rx_clock_pin,
   input  wire logic       rx_data_pin,
   input  wire logic       carrier_detect_n,
   output logic            flag_detect_n,
   output logic            ext_status_pulse,
   output logic            special_condition
);
   localparam int PTR_W = $clog2(FIFO_DEPTH + 1);

   typedef struct packed {
      logic                              clk_s1;
      logic                              clk_s2;
      logic                              clk_prev;
      logic                              dat_s1;
      logic                              dat_s2;
      logic                              dcd_s1;
      logic                              dcd_s2;
      logic [7:0]                        rx_config;
      logic [7:0]                        mode_config;
      logic [7:0]                        tx_config;
      logic [7:0]                        station;
      logic [7:0]                        line_config;
      logic                              enabled_prev;
      rx_state_t                         state;
      logic                              abort;
      logic [2:0]                        ones;
      logic [7:0]                        raw;
      logic [6:0]                        dly;
      logic [2:0]                        dly_cnt;
      logic [7:0]                        asm_sr;
      logic [3:0]                        bit_cnt;
      logic                              par;
      logic [15:0]                       crc;
      fifo_entry_t [FIFO_DEPTH-1:0]      fifo;
      logic [PTR_W-1:0]                  count;
      logic [2:0]                        residue;
      logic                              overrun;
      logic                              flag_n;
      logic                              ext_pulse;
      logic [7:0]                        rdata;
   } state_t;

   state_t s;
   state_t s_next;
   logic   tick;
   logic   flag_hit;
   logic   close_evt;
   logic   addr_done;
   logic   addr_match;
   logic   pop;

   // Bit-serial CCITT step, MSB-first register form
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : CRC_ZEROS);
   endfunction

   function automatic logic [15:0] crc_preset(input logic [7:0] line_cfg);
      return line_cfg[LINE_PRESET_ONES] ? CRC_ONES : CRC_ZEROS;
   endfunction

   function automatic logic [3:0] char_len(input logic [7:0] rx_cfg, input logic par_en);
      logic [1:0] code;
      code = rx_cfg[RXC_LEN_LO +: 2];
      return CHAR_LEN_LUT[code*4 +: 4] + {3'h0, par_en};
   endfunction

   function automatic logic [2:0] residue_code(input logic [2:0] bits);
      logic [2:0] idx;
      idx = bits + RESIDUE_BASE;
      return RESIDUE_LUT[idx*3 +: 3];
   endfunction

   function automatic logic addr_hit(input logic [7:0] ch, input logic [7:0] stn,
                                     input logic inhibit);
      logic [7:0] mask;
      mask = inhibit ? ADDR_MASK_HIGH : ADDR_MASK_FULL;
      return (((ch ^ stn) & mask) == '0) || ((ch & mask) == mask);
   endfunction

   // A full FIFO drops the character and flags overrun
   function automatic state_t push_entry(input state_t st, input fifo_entry_t e);
      state_t r;
      r = st;
      if (r.count < PTR_W'(FIFO_DEPTH)) begin
         r.fifo[r.count] = e;
         r.count = r.count + 1'b1;
      end else begin
         r.overrun = 1'b1;
      end
      return r;
   endfunction

   always_comb begin
      state_t      n;
      logic        bit_in;
      logic        rx_on;
      logic        hunt_cmd;
      logic        out_bit;
      logic [3:0]  total;
      logic [3:0]  snap_len;
      logic [7:0]  asm_nx;
      logic [14:0] view;
      logic [7:0]  ch;
      logic [7:0]  stat;
      fifo_entry_t ent;
      n          = s;
      bit_in     = s.dat_s2;
      rx_on      = s.rx_config[RXC_ENABLE]
                   & ~(s.rx_config[RXC_AUTO_ENABLE] & s.dcd_s2);
      hunt_cmd   = reg_write && reg_addr == ADDR_RX_CFG && reg_wdata[RXC_ENTER_HUNT];
      out_bit    = 1'b0;
      total      = char_len(s.rx_config, s.mode_config[MODE_PARITY_EN]);
      snap_len   = '0;
      asm_nx     = '0;
      view       = '0;
      ch         = '0;
      stat       = '0;
      ent        = '0;
      tick       = s.clk_s2 & ~s.clk_prev;
      flag_hit   = 1'b0;
      close_evt  = 1'b0;
      addr_done  = 1'b0;
      addr_match = 1'b0;
      pop        = 1'b0;

      // Only the second stage of each synchroniser is read
      n.clk_s1    = rx_clock_pin;
      n.clk_s2    = s.clk_s1;
      n.clk_prev  = s.clk_s2;
      n.dat_s1    = rx_data_pin;
      n.dat_s2    = s.dat_s1;
      n.dcd_s1    = carrier_detect_n;
      n.dcd_s2    = s.dcd_s1;
      n.rdata     = '0;
      n.ext_pulse = 1'b0;

      if (reg_write) begin
         case (reg_addr)
            ADDR_COMMAND: begin
               if (reg_wdata[7:6] == CMD_RESET_RX_CRC)
                  n.crc = crc_preset(s.line_config);
               if (reg_wdata[5:3] == CMD_ERROR_RESET)
                  n.overrun = 1'b0;
            end
            ADDR_RX_CFG:   n.rx_config = reg_wdata & ~(8'h01 << RXC_ENTER_HUNT);
            ADDR_MODE_CFG: n.mode_config = reg_wdata;
            ADDR_TX_CFG:   n.tx_config = reg_wdata;
            ADDR_STATION:  n.station = reg_wdata;
            ADDR_LINE_CFG: n.line_config = reg_wdata;
            default: ;
         endcase
      end

      if (reg_read) begin
         case (reg_addr)
            ADDR_RX_CFG:   n.rdata = s.rx_config;
            ADDR_MODE_CFG: n.rdata = s.mode_config;
            ADDR_TX_CFG:   n.rdata = s.tx_config;
            ADDR_STATION:  n.rdata = s.station;
            ADDR_LINE_CFG: n.rdata = s.line_config;
            ADDR_PRIMARY: begin
               stat[PRI_RX_AVAIL] = s.count != '0;
               stat[PRI_CARRIER]  = ~s.dcd_s2;
               stat[PRI_HUNT]     = s.state == ST_HUNT;
               stat[PRI_ABORT]    = s.abort;
               n.rdata = stat;
            end
            ADDR_SPECIAL: begin
               // Residue comes straight from its latch, not the FIFO
               stat[SPC_RESIDUE +: 3] = s.residue;
               stat[SPC_OVERRUN]      = s.overrun;
               if (s.count != '0) begin
                  stat[SPC_PARITY]  = s.fifo[0].parity_err;
                  stat[SPC_CRC_ERR] = s.fifo[0].crc_err;
                  stat[SPC_EOF]     = s.fifo[0].eof;
               end
               n.rdata = stat;
            end
            ADDR_DATA: begin
               n.rdata = s.fifo[0].data;
               pop = s.count != '0;
            end
            default: n.rdata = '0;
         endcase
      end

      if (pop) begin
         for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
            n.fifo[i] = s.fifo[i+1];
         end
         n.fifo[FIFO_DEPTH-1] = '0;
         n.count = s.count - 1'b1;
      end

      if (tick) begin
         n.raw  = {bit_in, s.raw[7:1]};
         n.ones = bit_in ? ((s.ones == ABORT_ONES) ? s.ones : s.ones + 3'h1) : '0;
         flag_hit = rx_on && (n.raw == FLAG_PATTERN);
         n.flag_n = ~flag_hit;
         if (!bit_in)
            n.abort = 1'b0;
         if (!rx_on) begin
         end else if (bit_in && n.ones == ABORT_ONES) begin
            // Character in assembly is lost on abort
            n.abort = 1'b1;
            n.state = ST_HUNT;
         end else if (flag_hit) begin
            if (s.state == ST_DATA) begin
               close_evt = 1'b1;
               ch  = s.asm_sr >> (CHAR_MAX - s.bit_cnt);
               ent = '{data: ch, eof: 1'b1, crc_err: s.crc != CRC_GOOD,
                       parity_err: 1'b0};
               n.residue = residue_code(s.bit_cnt[2:0]);
               n = push_entry(n, ent);
            end
            n.state   = ST_ADDR;
            n.dly_cnt = '0;
            n.bit_cnt = '0;
            n.par     = 1'b0;
            n.crc     = crc_preset(s.line_config);
         end else if (s.state == ST_HUNT) begin
         end else if (!bit_in && s.ones == STUFF_ONES) begin
         end else begin
            // Seven-bit delay keeps flag bits out of characters and CRC
            n.dly = {bit_in, s.dly[6:1]};
            if (s.dly_cnt == FLAG_DELAY) begin
               out_bit  = s.dly[0];
               n.crc    = crc_step(s.crc, out_bit);
               asm_nx   = {out_bit, s.asm_sr[7:1]};
               n.asm_sr = asm_nx;
               n.par    = s.par ^ out_bit;
               if (s.bit_cnt + 4'h1 >= total) begin
                  // Parity of an eight-bit character stays in bit 7; its first data bit falls off the bottom
                  snap_len = (total > CHAR_MAX) ? CHAR_MAX : total;
                  view     = {n.dly, asm_nx};
                  ch       = view[7:0];
                  ch       = 8'(view >> (CHAR_MAX - snap_len));
                  ent = '{data: ch, eof: 1'b0, crc_err: 1'b0,
                          parity_err: s.mode_config[MODE_PARITY_EN]
                                      & ~(n.par ^ s.mode_config[MODE_PARITY_SENSE])};
                  n.bit_cnt = '0;
                  n.par     = 1'b0;
                  if (s.state == ST_ADDR) begin
                     addr_done  = 1'b1;
                     addr_match = addr_hit(ch, s.station, s.rx_config[RXC_LOAD_INHIBIT]);
                     if (!s.rx_config[RXC_ADDR_SEARCH] || addr_match) begin
                        n = push_entry(n, ent);
                        n.state = ST_DATA;
                     end else begin
                        n.state = ST_SKIP;
                     end
                  end else if (s.state == ST_DATA) begin
                     n = push_entry(n, ent);
                  end
               end else begin
                  n.bit_cnt = s.bit_cnt + 4'h1;
               end
            end else begin
               n.dly_cnt = s.dly_cnt + 3'h1;
            end
         end
      end

      if (!rx_on || !s.enabled_prev || hunt_cmd)
         n.state = ST_HUNT;
      n.enabled_prev = rx_on;
      if (n.state == ST_HUNT)
         n.crc = crc_preset(n.line_config);
      n.ext_pulse = ((n.state == ST_HUNT) != (s.state == ST_HUNT))
                    || (n.abort != s.abort);
      s_next = n;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s        <= '0;
         s.flag_n <= 1'b1;
      end else begin
         s <= s_next;
      end
   end

   assign reg_rdata         = s.rdata;
   assign flag_detect_n     = s.flag_n;
   assign ext_status_pulse  = s.ext_pulse;
   assign special_condition = (s.count != '0) && s.fifo[0].eof;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   flag_pulse_a: assert property (flag_hit |=> !flag_detect_n ##1 flag_detect_n [*1]
                                  or !flag_detect_n)
      else $error("flag detect output missed a flag");
   hunt_cmd_a: assert property (reg_write && reg_addr == ADDR_RX_CFG
                                && reg_wdata[RXC_ENTER_HUNT] |=> s.state == ST_HUNT)
      else $error("enter hunt command ignored");
   hunt_nodata_a: assert property (s.state == ST_HUNT && !pop
                                   |=> s.count <= $past(s.count))
      else $error("character stored while hunting");
   ext_pulse_a: assert property ((s.state == ST_HUNT) != $past(s.state == ST_HUNT)
                                 |-> ext_status_pulse)
      else $error("hunt change gave no status event");
   abort_hunt_a: assert property (s.abort |-> s.state == ST_HUNT)
      else $error("abort did not force hunt");
   abort_end_a: assert property (tick && !s.dat_s2 |=> !s.abort)
      else $error("abort not ended by zero");
   auto_enable_a: assert property (s.rx_config[RXC_AUTO_ENABLE] && s.dcd_s2
                                   |=> s.state == ST_HUNT)
      else $error("receiver active with carrier lost");
   crc_preset_a: assert property (s.state == ST_HUNT && !reg_write
                                  |=> s.crc == crc_preset(s.line_config))
      else $error("checker not preset in hunt");
   // A line bit in the same cycle steps the checker, so only quiet cycles are judged
   crc_cmd_a: assert property (reg_write && reg_addr == ADDR_COMMAND && !tick
                               && reg_wdata[7:6] == CMD_RESET_RX_CRC
                               |=> s.crc == crc_preset(s.line_config))
      else $error("checker preset command ignored");
   close_status_a: assert property (close_evt && s.count == '0 && !pop
                                    |=> special_condition
                                    && s.fifo[0].crc_err == ($past(s.crc) != CRC_GOOD))
      else $error("closing flag status wrong");
   addr_reject_a: assert property (addr_done && s.rx_config[RXC_ADDR_SEARCH]
                                   && !addr_match |=> s.state == ST_SKIP)
      else $error("foreign frame not discarded");
   addr_open_a: assert property (addr_done && !s.rx_config[RXC_ADDR_SEARCH]
                                 |=> s.state == ST_DATA)
      else $error("frame dropped with search off");

   frame_close_c: cover property (close_evt ##1 special_condition);
   frame_skip_c: cover property (addr_done && !addr_match ##1 s.state == ST_SKIP);
   abort_seen_c: cover property ($rose(s.abort));
   overrun_c: cover property ($rose(s.overrun));
endmodule  // sdlc_receive_framer
`default_nettype wire

// >>> inc/sdlc_rx_pkg.sv
`default_nettype none
package sdlc_rx_pkg;
   // Register indexes on the plain register port
   localparam logic [3:0] ADDR_COMMAND  = 4'h0;
   localparam logic [3:0] ADDR_RX_CFG   = 4'h1;
   localparam logic [3:0] ADDR_MODE_CFG = 4'h2;
   localparam logic [3:0] ADDR_TX_CFG   = 4'h3;
   localparam logic [3:0] ADDR_STATION  = 4'h4;
   localparam logic [3:0] ADDR_LINE_CFG = 4'h5;
   localparam logic [3:0] ADDR_PRIMARY  = 4'h6;
   localparam logic [3:0] ADDR_SPECIAL  = 4'h7;
   localparam logic [3:0] ADDR_DATA     = 4'h8;
   // rx_config_reg fields
   localparam int RXC_ENABLE       = 0;
   localparam int RXC_LOAD_INHIBIT = 1;
   localparam int RXC_ADDR_SEARCH  = 2;
   localparam int RXC_ENTER_HUNT   = 4;
   localparam int RXC_AUTO_ENABLE  = 5;
   localparam int RXC_LEN_LO       = 6;
   // mode_config_reg, tx_config_reg, line_config_reg fields
   localparam int MODE_PARITY_SENSE = 1;
   localparam int MODE_PARITY_EN    = 6;
   localparam int TXC_CRC_SELECT    = 2;
   localparam int LINE_PRESET_ONES  = 7;
   // command_reg codes
   localparam logic [1:0] CMD_RESET_RX_CRC = 2'h1;
   localparam logic [2:0] CMD_ERROR_RESET  = 3'h6;
   // Status bit positions
   localparam int PRI_RX_AVAIL = 0;
   localparam int PRI_CARRIER  = 3;
   localparam int PRI_HUNT     = 4;
   localparam int PRI_ABORT    = 7;
   localparam int SPC_RESIDUE  = 1;
   localparam int SPC_PARITY   = 4;
   localparam int SPC_OVERRUN  = 5;
   localparam int SPC_CRC_ERR  = 6;
   localparam int SPC_EOF      = 7;
   // Line framing constants
   localparam logic [7:0]  FLAG_PATTERN = 8'h7E;
   localparam logic [2:0]  ABORT_ONES   = 3'h7;
   localparam logic [2:0]  STUFF_ONES   = 3'h5;
   localparam logic [2:0]  FLAG_DELAY   = 3'h7;
   localparam logic [3:0]  CHAR_MAX     = 4'h8;
   localparam logic [15:0] CRC_POLY     = 16'h1021;
   localparam logic [15:0] CRC_GOOD     = 16'h1D0F;
   localparam logic [15:0] CRC_ONES     = 16'hFFFF;
   localparam logic [15:0] CRC_ZEROS    = 16'h0000;
   localparam logic [7:0]  ADDR_MASK_FULL = 8'hFF;
   localparam logic [7:0]  ADDR_MASK_HIGH = 8'hF0;
   // Length code 00,01,10,11 gives 5,7,6,8 bits
   localparam logic [15:0] CHAR_LEN_LUT = {4'h8, 4'h6, 4'h7, 4'h5};
   // Residue codes in order of rising valid bit count
   localparam logic [23:0] RESIDUE_LUT  =
      {3'h0, 3'h7, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4};
   localparam logic [2:0]  RESIDUE_BASE = 3'h5;

   typedef enum logic [1:0] {
      ST_HUNT = 2'h0,
      ST_ADDR = 2'h1,
      ST_DATA = 2'h3,
      ST_SKIP = 2'h2
   } rx_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic       eof;
      logic       crc_err;
      logic       parity_err;
   } fifo_entry_t;
endpackage
`default_nettype wire

// >>> test/sdlc_line_station.sv
`default_nettype none
module sdlc_line_station #(
   parameter int HALF_NS = 200
) (
   output logic line_clock,
   output logic line_data
);
   timeunit 1ns;
   timeprecision 100ps;
   int          ones_run;
   logic [15:0] crc;
   // Clock stands still low between frames
   initial begin
      line_clock = 1'b0;
      line_data = 1'b1;
      ones_run = 0;
   end
   // Data moves with the clock low, so it is stable around the rising edge
   task automatic put_bit(input logic b);
      line_data = b;
      #HALF_NS line_clock = 1'b1;
      #HALF_NS line_clock = 1'b0;
   endtask
   task automatic put_raw(input logic [7:0] v);
      for (int i = 0; i < 8; i++) put_bit(v[i]);
      ones_run = 0;
   endtask
   task automatic put_stuffed(input logic b);
      put_bit(b);
      ones_run = b ? ones_run + 1 : 0;
      if (ones_run == 5) begin
         put_bit(1'b0);
         ones_run = 0;
      end
   endtask
   // Released line shows the inverse of the last bit, never a held value
   task automatic send_flag();
      put_raw(8'h7E);
      #HALF_NS line_data = ~line_data;
   endtask
   task automatic send_frame(input logic [7:0] b[$], input logic ones, input logic abort);
      logic fb;
      #13;
      crc = ones ? 16'hFFFF : 16'h0000;
      put_raw(8'h7E);
      foreach (b[i]) begin
         for (int k = 0; k < 8; k++) begin
            fb = crc[15] ^ b[i][k];
            crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
            put_stuffed(b[i][k]);
         end
      end
      if (abort) begin
         put_raw(8'hFF);
      end else begin
         crc = ~crc;
         for (int k = 15; k >= 0; k--) put_stuffed(crc[k]);
         put_raw(8'h7E);
      end
      #HALF_NS line_data = ~line_data;
   endtask
endmodule // sdlc_line_station
`default_nettype wire

// >>> test/test_sdlc_receive_framer.sv
`default_nettype none
module test_sdlc_receive_framer
   import sdlc_rx_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clock, rst, reg_write, reg_read, carrier_detect_n;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic       rx_clock_pin, rx_data_pin, flag_detect_n, ext_status_pulse, special_condition;
   logic       fdn_q, line_done, first_par;
   int         err_total, checked, flag_cnt, ext_cnt;

   sdlc_receive_framer DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .rx_clock_pin(rx_clock_pin), .rx_data_pin(rx_data_pin),
      .carrier_detect_n(carrier_detect_n), .flag_detect_n(flag_detect_n),
      .ext_status_pulse(ext_status_pulse), .special_condition(special_condition));
   sdlc_line_station station (.line_clock(rx_clock_pin), .line_data(rx_data_pin));

   initial clock = 1'b0;
   always #25 clock = ~clock;
   always @(posedge clock) begin
      fdn_q <= flag_detect_n;
      if (fdn_q === 1'b1 && flag_detect_n === 1'b0) flag_cnt <= flag_cnt + 1;
      if (ext_status_pulse === 1'b1) ext_cnt <= ext_cnt + 1;
   end

   task automatic summarize();
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic hunt_is(input logic e);
      logic [7:0] s;
      repeat (4) @(posedge clock);
      rd(ADDR_PRIMARY, s);
      chk1(s[PRI_HUNT], e);
   endtask
   // Drains the FIFO while the line runs; stops at end-of-frame or when the line is quiet
   task automatic collect(output logic [7:0] got[$], output logic [7:0] fin);
      logic [7:0] s, d;
      int         idle;
      got = {};
      fin = 8'h00;
      idle = 0;
      for (int n = 0; n < 4000 && idle < 200; n++) begin
         if (line_done) idle++;
         rd(ADDR_PRIMARY, s);
         if (s[PRI_RX_AVAIL] === 1'b1) begin
            rd(ADDR_SPECIAL, s);
            if (got.size() == 0) first_par = s[SPC_PARITY];
            if (s[SPC_EOF] === 1'b1) chk1(special_condition, 1'b1);
            if (s[SPC_EOF] === 1'b1) fin = s;
            rd(ADDR_DATA, d);
            got.push_back(d);
            if (s[SPC_EOF] === 1'b1) wr(ADDR_COMMAND, 8'h30);
            if (s[SPC_EOF] === 1'b1) idle = 201;
         end
      end
      if (idle < 200) begin
         err_total++;
         summarize();
      end
   endtask
   task automatic frame(input logic [7:0] b[$], input logic ones,
                        output logic [7:0] got[$], output logic [7:0] fin);
      line_done = 1'b0;
      fork
         begin
            station.send_frame(b, ones, 1'b0);
            line_done = 1'b1;
         end
         collect(got, fin);
      join
   endtask

   task automatic s_regs();
      logic [7:0] s;
      rd(ADDR_PRIMARY, s);
      chk1(s[PRI_HUNT], 1'b1);
      rd(4'hF, s);
      chk8(s, 8'h00);
      wr(ADDR_STATION, 8'h31);
      wr(ADDR_LINE_CFG, 8'h80);
      wr(ADDR_TX_CFG, 8'h00);
      wr(ADDR_COMMAND, 8'h40);
      wr(ADDR_RX_CFG, 8'hD1);
      rd(ADDR_RX_CFG, s);
      chk8(s, 8'hC1);
   endtask
   task automatic s_hunt();
      int f0, e0;
      f0 = flag_cnt;
      e0 = ext_cnt;
      station.send_flag();
      hunt_is(1'b0);
      chk1(flag_cnt == f0 + 1, 1'b1);
      chk1(ext_cnt == e0 + 1, 1'b1);
      wr(ADDR_RX_CFG, 8'hC1);
      hunt_is(1'b0);
      wr(ADDR_RX_CFG, 8'hD1);
      hunt_is(1'b1);
      chk1(ext_cnt == e0 + 2, 1'b1);
   endtask
   task automatic s_frames();
      logic [7:0] got[$];
      logic [7:0] fin;
      frame('{8'h5A, 8'h11, 8'h22}, 1'b1, got, fin);
      chk8(got[0], 8'h5A);
      chk8(got[1], 8'h11);
      chk8(got[2], 8'h22);
      chk1(fin[SPC_EOF], 1'b1);
      chk1(fin[SPC_CRC_ERR], 1'b0);
      chk8({5'h00, fin[SPC_RESIDUE +: 3]}, 8'h03);
      wr(ADDR_LINE_CFG, 8'h00);
      frame('{8'h5A, 8'h11}, 1'b1, got, fin);
      chk1(fin[SPC_CRC_ERR], 1'b1);
      frame('{8'h5A, 8'h11}, 1'b0, got, fin);
      chk1(fin[SPC_CRC_ERR], 1'b0);
      wr(ADDR_LINE_CFG, 8'h80);
   endtask
   task automatic s_address();
      logic [7:0] got[$];
      logic [7:0] fin;
      logic [7:0] cfg[5] = '{8'hC5, 8'hC5, 8'hC5, 8'hC7, 8'hC5};
      logic [7:0] adr[5] = '{8'h55, 8'hFF, 8'h31, 8'h3C, 8'h3C};
      logic       hit[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_RX_CFG, cfg[i]);
         frame('{adr[i], 8'h42}, 1'b1, got, fin);
         chk1(got.size() > 0, hit[i]);
         if (hit[i]) chk8(got[0], adr[i]);
      end
      wr(ADDR_RX_CFG, 8'h01);
      frame('{8'hA7, 8'h3C, 8'h00}, 1'b1, got, fin);
      chk8(got[0], 8'hA7);
      chk8(got[1], 8'hE5);
      wr(ADDR_RX_CFG, 8'hC1);
   endtask
   task automatic s_parity();
      logic [7:0] got[$];
      logic [7:0] fin;
      wr(ADDR_MODE_CFG, 8'h42);
      wr(ADDR_RX_CFG, 8'h41);
      frame('{8'h03, 8'h21}, 1'b1, got, fin);
      chk8(got[0], 8'h03);
      chk1(first_par, 1'b0);
      frame('{8'h07, 8'h21}, 1'b1, got, fin);
      chk1(first_par, 1'b1);
      wr(ADDR_MODE_CFG, 8'h00);
      wr(ADDR_RX_CFG, 8'hC1);
   endtask
   // Nobody reads during the frame, so the check bytes and end mark find the FIFO full
   task automatic s_overrun();
      logic [7:0] got[$];
      logic [7:0] s;
      station.send_frame('{8'h5A, 8'h11, 8'h22}, 1'b1, 1'b0);
      rd(ADDR_SPECIAL, s);
      chk1(s[SPC_OVERRUN], 1'b1);
      wr(ADDR_COMMAND, 8'h30);
      rd(ADDR_SPECIAL, s);
      chk1(s[SPC_OVERRUN], 1'b0);
      line_done = 1'b1;
      collect(got, s);
      chk8(8'(got.size()), 8'h03);
      chk8(got[0], 8'h5A);
   endtask
   task automatic s_abort();
      logic [7:0] got[$];
      logic [7:0] s;
      int         e0;
      e0 = ext_cnt;
      station.send_frame('{8'h5A, 8'h11}, 1'b1, 1'b1);
      hunt_is(1'b1);
      rd(ADDR_PRIMARY, s);
      chk1(s[PRI_ABORT], 1'b1);
      chk1(ext_cnt == e0 + 1, 1'b1);
      line_done = 1'b1;
      collect(got, s);
      station.send_flag();
      hunt_is(1'b0);
      rd(ADDR_PRIMARY, s);
      chk1(s[PRI_ABORT], 1'b0);
      chk1(ext_cnt == e0 + 3, 1'b1);
   endtask
   task automatic s_carrier();
      wr(ADDR_RX_CFG, 8'hE1);
      carrier_detect_n <= 1'b1;
      hunt_is(1'b1);
      station.send_flag();
      hunt_is(1'b1);
      carrier_detect_n <= 1'b0;
      hunt_is(1'b1);
      station.send_flag();
      hunt_is(1'b0);
   endtask

   initial begin
      rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      carrier_detect_n = 1'b0;
      line_done = 1'b0;
      err_total = 0;
      checked = 0;
      flag_cnt = 0;
      ext_cnt = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      s_regs();
      s_hunt();
      s_frames();
      s_address();
      s_parity();
      s_overrun();
      s_abort();
      s_carrier();
      summarize();
   end
endmodule // test_sdlc_receive_framer
`default_nettype wire
